// >>> verilog/lsm_pkg.sv
// Purpose: Shared constants and types for the loss-of-signal monitor
// Assumes: One channel per instance, registers on a plain strobe port
// Notes:   Offsets are word indices on the register port
package lsm_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [3:0] LSM_ADDR_STATUS  = 4'h0; // line_alarm_status
  localparam logic [3:0] LSM_ADDR_MONCTL  = 4'h2; // receive_monitor_control
  localparam logic [3:0] LSM_ADDR_OUTCTL  = 4'h3; // receive_output_control
  localparam logic [3:0] LSM_ADDR_IRQ_ST  = 4'h4;
  localparam logic [3:0] LSM_ADDR_IRQ_CLR = 4'h5;
  localparam logic [3:0] LSM_ADDR_IRQ_EN  = 4'h6;
  localparam logic [3:0] LSM_ADDR_RATE    = 4'h7;

  localparam logic [4:0] LSM_MONCTL_RST = 5'h00;
  localparam logic [4:0] LSM_OUTCTL_RST = 5'h00;
  localparam logic [1:0] LSM_RATE_RST   = 2'h0;
  localparam logic [3:0] LSM_IRQ_RST    = 4'h0;

  // Interrupt bit positions
  localparam int LSM_IRQ_LOSS_SET = 0;
  localparam int LSM_IRQ_LOSS_CLR = 1;
  localparam int LSM_IRQ_AMP_SET  = 2;
  localparam int LSM_IRQ_PULSE_SET = 3;

  // ************************************************************
  // Detector timing, in unit intervals
  // ************************************************************
  localparam logic [7:0] LSM_ZERO_LIMIT  = 8'ha0;  // 160 zeros
  localparam logic [4:0] LSM_WIN_LAST    = 5'h1f;  // 32-bit window
  localparam logic [5:0] LSM_WIN_ONES    = 6'h0a;  // 10 ones
  localparam logic [2:0] LSM_WIN_GOOD    = 3'h4;   // 4 windows
  localparam logic [4:0] LSM_AMP_FILT_UI = 5'h10;  // 16 UI filter

  // ************************************************************
  // Amplitude thresholds in mV
  // ************************************************************
  localparam logic [7:0] LSM_DS3_EQ_DECL  = 8'h16; // 22
  localparam logic [7:0] LSM_DS3_NEQ_DECL = 8'h11; // 17
  localparam logic [7:0] LSM_STS_EQ_DECL  = 8'h19; // 25
  localparam logic [7:0] LSM_STS_NEQ_DECL = 8'h14; // 20
  localparam logic [7:0] LSM_DS3_EQ_CLR   = 8'h5a; // 90
  localparam logic [7:0] LSM_DS3_NEQ_CLR  = 8'h46; // 70
  localparam logic [7:0] LSM_STS_EQ_CLR   = 8'h73; // 115
  localparam logic [7:0] LSM_STS_NEQ_CLR  = 8'h5a; // 90

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    LSM_RATE_DS3 = 2'b00,
    LSM_RATE_STS = 2'b01,
    LSM_RATE_E3  = 2'b10
  } lsm_rate_t;

  typedef struct packed {
    logic       rsvd;
    logic       endec_disable;
    logic       amplitude_detector_disable;
    logic       pulse_detector_disable;
    logic       equalizer_enable;
  } lsm_monctl_t;

  typedef struct packed {
    logic       single_rail;
    logic       mute_on_loss_bit;
    logic       rx_off;
    logic       clk_invert;
    logic       rsvd;
  } lsm_outctl_t;

  typedef struct packed {
    logic       lock_loss_flag;
    logic       signal_loss_flag;
    logic       amplitude_loss_flag;
    logic       pulse_absence_flag;
    logic       drive_monitor_flag;
  } lsm_status_t;

endpackage

// >>> verilog/lsm_pulse_absence.sv
// Purpose: Pulse-absence detector on the recovered bit stream
// Assumes: bit_en marks one unit interval of recovered data
// Notes:   Held cleared while disabled
`timescale 1ns/100ps
`default_nettype none
module lsm_pulse_absence
  import lsm_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic bit_en,
  input  wire logic one_bit,
  input  wire logic disable_det,
  output logic      absent
);

  logic [7:0] zero_cnt_reg;
  logic [4:0] win_cnt_reg;
  logic [5:0] ones_reg;
  logic [2:0] good_reg;
  logic [5:0] ones_next;

  assign ones_next = ones_reg + {5'h00, one_bit};

  // ************************************************************
  // Zero run and declare
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst || disable_det) begin
      zero_cnt_reg <= 8'h00;
      absent       <= 1'b0;
    end else if (bit_en) begin
      if (one_bit || absent) begin
        zero_cnt_reg <= 8'h00;
      end else if (zero_cnt_reg == LSM_ZERO_LIMIT - 8'h01) begin
        zero_cnt_reg <= 8'h00;
        absent       <= 1'b1;
      end else begin
        zero_cnt_reg <= zero_cnt_reg + 8'h01;
      end
      if (absent && win_cnt_reg == LSM_WIN_LAST && ones_next >= LSM_WIN_ONES &&
          good_reg == LSM_WIN_GOOD - 3'h1) begin
        absent <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Density windows while declared
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst || disable_det || !absent) begin
      win_cnt_reg <= 5'h00;
      ones_reg    <= 6'h00;
      good_reg    <= 3'h0;
    end else if (bit_en) begin
      win_cnt_reg <= win_cnt_reg + 5'h01;
      if (win_cnt_reg == LSM_WIN_LAST) begin
        ones_reg <= 6'h00;
        good_reg <= (ones_next >= LSM_WIN_ONES) ? good_reg + 3'h1 : 3'h0;
      end else begin
        ones_reg <= ones_next;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  zero_run_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(absent) |-> $past(zero_cnt_reg) == 8'h9f && $past(bit_en))
    else $error("Pulse absence declared off the zero-run limit");

  window_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(absent) && !$past(disable_det) |-> $past(good_reg) == 3'h3)
    else $error("Pulse absence cleared without four good windows");

  pulse_dis_a: assert property (@(posedge clk_sys) disable iff (rst)
    disable_det |=> !absent)
    else $error("Pulse absence declared while disabled");

endmodule
`default_nettype wire

// >>> verilog/lsm_monitor.sv
// Purpose: Per-channel loss-of-signal monitor with mute on loss
// Assumes: Recovered rails and comparator results are on clk_sys
// Notes:   bit_en marks each unit interval; pins pass two flops
`timescale 1ns/100ps
`default_nettype none
module lsm_monitor
  import lsm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [4:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [4:0]      reg_rdata,
  // Recovered data
  input  wire logic       bit_en,
  input  wire logic       rail_pos_in,
  input  wire logic       rail_neg_in,
  // Amplitude comparators
  input  wire logic       amp_below_declare,
  input  wire logic       amp_above_clear,
  output logic [7:0]      declare_thr_mv,
  output logic [7:0]      clear_thr_mv,
  // Neighbour status
  input  wire logic       lock_loss_flag,
  input  wire logic       drive_monitor_flag,
  // Pins
  input  wire logic       hw_mode_pin,
  input  wire logic       global_mute_pin,
  // Outputs
  output logic            signal_loss_flag,
  output logic            positive_rail_out,
  output logic            negative_rail_out,
  output logic            irq
);

  // ************************************************************
  // Declarations
  // ************************************************************
  lsm_monctl_t monctl_reg;
  lsm_outctl_t outctl_reg;
  lsm_rate_t   rate_reg;
  lsm_status_t status;
  logic [3:0]  irq_st_reg;
  logic [3:0]  irq_en_reg;
  logic [3:0]  irq_ev;
  logic [1:0]  pin_meta_reg;
  logic [1:0]  pin_sync_reg;
  logic        hw_mode;
  logic        amp_flag_reg;
  logic        amp_flag_d_reg;
  logic        pulse_flag_d_reg;
  logic [4:0]  amp_cnt_reg;
  logic        pulse_flag;
  logic        amp_dis;
  logic        pulse_dis;
  logic        loss_next;
  logic        mute_en;
  logic        mute_now;
  logic        wr_monctl;
  logic        wr_outctl;
  logic        wr_rate;
  logic        wr_irq_clr;
  logic        wr_irq_en;
  logic [4:0]  rdata_next;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else begin
      pin_meta_reg <= {hw_mode_pin, global_mute_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign hw_mode = pin_sync_reg[1];

  // ************************************************************
  // Register writes
  // ************************************************************
  assign wr_monctl  = reg_wr && reg_addr == LSM_ADDR_MONCTL;
  assign wr_outctl  = reg_wr && reg_addr == LSM_ADDR_OUTCTL;
  assign wr_rate    = reg_wr && reg_addr == LSM_ADDR_RATE;
  assign wr_irq_clr = reg_wr && reg_addr == LSM_ADDR_IRQ_CLR;
  assign wr_irq_en  = reg_wr && reg_addr == LSM_ADDR_IRQ_EN;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      monctl_reg <= lsm_monctl_t'(LSM_MONCTL_RST);
    end else if (wr_monctl) begin
      monctl_reg <= lsm_monctl_t'(reg_wdata);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      outctl_reg <= lsm_outctl_t'(LSM_OUTCTL_RST);
    end else if (wr_outctl) begin
      outctl_reg <= lsm_outctl_t'(reg_wdata);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rate_reg <= lsm_rate_t'(LSM_RATE_RST);
    end else if (wr_rate) begin
      rate_reg <= lsm_rate_t'(reg_wdata[1:0]);
    end
  end

  // Disable bits only act under host control; E3 rate disables pulse detection in both modes
  assign amp_dis   = !hw_mode && monctl_reg.amplitude_detector_disable;
  assign pulse_dis = (!hw_mode && monctl_reg.pulse_detector_disable) ||
                     rate_reg == LSM_RATE_E3;

  // ************************************************************
  // Amplitude thresholds for the comparator DACs
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      declare_thr_mv <= LSM_DS3_EQ_DECL;
      clear_thr_mv   <= LSM_DS3_EQ_CLR;
    end else begin
      unique case (rate_reg)
        LSM_RATE_DS3: begin
          declare_thr_mv <= monctl_reg.equalizer_enable ? LSM_DS3_EQ_DECL
                                                        : LSM_DS3_NEQ_DECL;
          clear_thr_mv   <= monctl_reg.equalizer_enable ? LSM_DS3_EQ_CLR
                                                        : LSM_DS3_NEQ_CLR;
        end
        LSM_RATE_STS: begin
          declare_thr_mv <= monctl_reg.equalizer_enable ? LSM_STS_EQ_DECL
                                                        : LSM_STS_NEQ_DECL;
          clear_thr_mv   <= monctl_reg.equalizer_enable ? LSM_STS_EQ_CLR
                                                        : LSM_STS_NEQ_CLR;
        end
        default: begin
          // E3 thresholds live in the analog front end
          declare_thr_mv <= 8'h00;
          clear_thr_mv   <= 8'h00;
        end
      endcase
    end
  end

  // ************************************************************
  // Amplitude detector with unit-interval filter
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst || amp_dis) begin
      amp_flag_reg <= 1'b0;
      amp_cnt_reg  <= 5'h00;
    end else if (bit_en) begin
      if (!amp_flag_reg) begin
        if (!amp_below_declare) begin
          amp_cnt_reg <= 5'h00;
        end else if (amp_cnt_reg == LSM_AMP_FILT_UI - 5'h01) begin
          amp_cnt_reg  <= 5'h00;
          amp_flag_reg <= 1'b1;
        end else begin
          amp_cnt_reg <= amp_cnt_reg + 5'h01;
        end
      end else begin
        if (!amp_above_clear) begin
          amp_cnt_reg <= 5'h00;
        end else if (amp_cnt_reg == LSM_AMP_FILT_UI - 5'h01) begin
          amp_cnt_reg  <= 5'h00;
          amp_flag_reg <= 1'b0;
        end else begin
          amp_cnt_reg <= amp_cnt_reg + 5'h01;
        end
      end
    end
  end

  // ************************************************************
  // Pulse-absence detector
  // ************************************************************
  lsm_pulse_absence u_pulse (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .bit_en      (bit_en),
    .one_bit     (rail_pos_in || rail_neg_in),
    .disable_det (pulse_dis),
    .absent      (pulse_flag)
  );

  // ************************************************************
  // Combined loss
  // ************************************************************
  assign loss_next = amp_flag_reg || pulse_flag;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      signal_loss_flag <= 1'b0;
    end else begin
      signal_loss_flag <= loss_next;
    end
  end

  // ************************************************************
  // Mute and rail outputs
  // ************************************************************
  assign mute_en  = hw_mode ? pin_sync_reg[0] : outctl_reg.mute_on_loss_bit;
  assign mute_now = mute_en && signal_loss_flag;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      positive_rail_out <= 1'b0;
      negative_rail_out <= 1'b0;
    end else if (mute_now) begin
      positive_rail_out <= 1'b0;
      negative_rail_out <= 1'b0;
    end else if (bit_en) begin
      positive_rail_out <= rail_pos_in;
      negative_rail_out <= rail_neg_in;
    end
  end

  // ************************************************************
  // Status and interrupts
  // ************************************************************
  assign status.lock_loss_flag      = lock_loss_flag;
  assign status.signal_loss_flag    = signal_loss_flag;
  assign status.amplitude_loss_flag = amp_flag_reg;
  assign status.pulse_absence_flag  = pulse_flag;
  assign status.drive_monitor_flag  = drive_monitor_flag;

  assign irq_ev[LSM_IRQ_LOSS_SET]  = loss_next && !signal_loss_flag;
  assign irq_ev[LSM_IRQ_LOSS_CLR]  = !loss_next && signal_loss_flag;
  assign irq_ev[LSM_IRQ_AMP_SET]   = amp_flag_reg && !amp_flag_d_reg;
  assign irq_ev[LSM_IRQ_PULSE_SET] = pulse_flag && !pulse_flag_d_reg;

  // Previous flag values for rise detection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      amp_flag_d_reg   <= 1'b0;
      pulse_flag_d_reg <= 1'b0;
    end else begin
      amp_flag_d_reg   <= amp_flag_reg;
      pulse_flag_d_reg <= pulse_flag;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_st_reg <= LSM_IRQ_RST;
    end else begin
      irq_st_reg <= (irq_st_reg & ~(wr_irq_clr ? reg_wdata[3:0] : 4'h0)) | irq_ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_en_reg <= LSM_IRQ_RST;
    end else if (wr_irq_en) begin
      irq_en_reg <= reg_wdata[3:0];
    end
  end

  assign irq = |(irq_st_reg & irq_en_reg);

  // ************************************************************
  // Register reads
  // ************************************************************
  always_comb begin
    rdata_next = 5'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        LSM_ADDR_STATUS: rdata_next = status;
        LSM_ADDR_MONCTL: rdata_next = monctl_reg;
        LSM_ADDR_OUTCTL: rdata_next = outctl_reg;
        LSM_ADDR_IRQ_ST: rdata_next = {1'b0, irq_st_reg};
        LSM_ADDR_IRQ_EN: rdata_next = {1'b0, irq_en_reg};
        LSM_ADDR_RATE:   rdata_next = {3'h0, rate_reg};
        default:         rdata_next = 5'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 5'h00;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  loss_or_a: assert property (@(posedge clk_sys) disable iff (rst)
    (amp_flag_reg || pulse_flag) |=> signal_loss_flag)
    else $error("Loss not raised by a detector state");

  loss_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
    !amp_flag_reg && !pulse_flag |=> !signal_loss_flag)
    else $error("Loss held without a detector state");

  amp_declare_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(amp_flag_reg) |-> $past(amp_cnt_reg) == 5'h0f && $past(amp_below_declare))
    else $error("Amplitude loss declared without full filter");

  amp_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(amp_flag_reg) && !$past(amp_dis) |-> $past(amp_cnt_reg) == 5'h0f &&
    $past(amp_above_clear))
    else $error("Amplitude loss cleared without full filter");

  amp_dis_a: assert property (@(posedge clk_sys) disable iff (rst)
    amp_dis |=> !amp_flag_reg)
    else $error("Amplitude loss set while disabled");

  both_dis_a: assert property (@(posedge clk_sys) disable iff (rst)
    amp_dis && pulse_dis ##1 amp_dis && pulse_dis |=> !signal_loss_flag)
    else $error("Loss declared with both detectors disabled");

  mute_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    mute_now |=> !positive_rail_out && !negative_rail_out)
    else $error("Rails not muted during loss");

  resume_a: assert property (@(posedge clk_sys) disable iff (rst)
    bit_en && !mute_now |=> positive_rail_out == $past(rail_pos_in) &&
    negative_rail_out == $past(rail_neg_in))
    else $error("Rails not passing recovered data");

  status_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == LSM_ADDR_STATUS |=> reg_rdata[2] == $past(amp_flag_reg) &&
    reg_rdata[1] == $past(pulse_flag) && reg_rdata[3] == $past(signal_loss_flag))
    else $error("Status read does not match detector state");

endmodule
`default_nettype wire

// >>> testbench/lsm_framer_model.sv
// Purpose: Receiving terminal model that counts delivered rail pulses
// Assumes: Rails are sampled on clk_sys
// Notes:   Count clears on clr
`timescale 1ns/100ps
`default_nettype none
module lsm_framer_model (
  input  wire logic   clk_sys,
  input  wire logic   rst,
  input  wire logic   clr,
  input  wire logic   rail_pos,
  input  wire logic   rail_neg,
  output logic [15:0] ones_cnt
);
  // ****************************************
  // Pulse counter
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      ones_cnt <= 16'h0000;
    end else if (rail_pos || rail_neg) begin
      ones_cnt <= ones_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the loss-of-signal monitor
// Assumes: One channel, bit_en pulsed while traffic runs
// Notes:   Reads are noted in a queue and compared by the bench's clocked check process
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import lsm_pkg::*;
  logic       clk_sys, rst, reg_wr, reg_rd, bit_en, rail_pos_in, rail_neg_in;
  logic       amp_below_declare, amp_above_clear, lock_loss_flag, drive_monitor_flag;
  logic       hw_mode_pin, global_mute_pin, signal_loss_flag, irq, frm_clr;
  logic       positive_rail_out, negative_rail_out, rd_pend, rail_chk, exp_mute;
  logic [3:0] reg_addr;
  logic [4:0] reg_wdata, reg_rdata;
  logic [7:0] declare_thr_mv, clear_thr_mv;
  logic [1:0] prev;
  logic [15:0] ones_cnt;
  logic [4:0] rd_q [$];
  logic [7:0] thr_d [4] = '{8'h16, 8'h11, 8'h19, 8'h14};
  logic [7:0] thr_c [4] = '{8'h5a, 8'h46, 8'h73, 8'h5a};
  int         mismatches, cmp_count, cyc;

  lsm_monitor dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bit_en(bit_en),
    .rail_pos_in(rail_pos_in), .rail_neg_in(rail_neg_in), .amp_below_declare(amp_below_declare),
    .amp_above_clear(amp_above_clear), .declare_thr_mv(declare_thr_mv),
    .clear_thr_mv(clear_thr_mv), .lock_loss_flag(lock_loss_flag),
    .drive_monitor_flag(drive_monitor_flag), .hw_mode_pin(hw_mode_pin),
    .global_mute_pin(global_mute_pin), .signal_loss_flag(signal_loss_flag),
    .positive_rail_out(positive_rail_out), .negative_rail_out(negative_rail_out), .irq(irq));
  lsm_framer_model frm_u (.clk_sys(clk_sys), .rst(rst), .clr(frm_clr),
    .rail_pos(positive_rail_out), .rail_neg(negative_rail_out), .ones_cnt(ones_cnt));

  // ****************************************
  // Clock, timeout, checks
  // ****************************************
  always #5 clk_sys = ~clk_sys;
  task automatic end_sim();
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      end_sim();
    end
    if (rail_chk) check("rails", {6'h00, positive_rail_out, negative_rail_out},
                        exp_mute ? 8'h00 : {6'h00, prev});
    if (bit_en) prev <= {rail_pos_in, rail_neg_in};
    if (rd_pend) check("reg_rdata", {3'h0, reg_rdata}, {3'h0, rd_q.pop_front()});
    rd_pend <= reg_rd;
  end

  // ****************************************
  // Drivers
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [4:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [4:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic bits(input int n, input bit z, input bit ab, input bit ac);
    bit p;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      p = 1'($urandom % 2);
      bit_en <= 1'b1;
      rail_pos_in <= z ? 1'b0 : p;
      rail_neg_in <= z ? 1'b0 : !p;
      amp_below_declare <= ab;
      amp_above_clear <= ac;
    end
    @(posedge clk_sys);
    bit_en <= 1'b0;
    #1;
  endtask
  task automatic fclr();
    @(posedge clk_sys);
    frm_clr <= 1'b1;
    @(posedge clk_sys);
    frm_clr <= 1'b0;
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {clk_sys, reg_wr, reg_rd, bit_en, rail_pos_in, rail_neg_in, amp_below_declare} = '0;
    {amp_above_clear, hw_mode_pin, global_mute_pin, frm_clr, rd_pend, rail_chk} = '0;
    {reg_addr, reg_wdata, prev, exp_mute, mismatches, cmp_count, cyc} = '0;
    {lock_loss_flag, drive_monitor_flag} = 2'b11;
    rst = 1'b1;
    void'($urandom(56873));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check("decl_thr", declare_thr_mv, 8'h16);
    check("clr_thr", clear_thr_mv, 8'h5a);
    check("loss", {7'h0, signal_loss_flag}, 8'h00);
    wr(LSM_ADDR_STATUS, 5'h1f);
    rd(LSM_ADDR_STATUS, 5'h11);
    rd(4'h1, 5'h00);
    rd(LSM_ADDR_MONCTL, LSM_MONCTL_RST);
    rd(LSM_ADDR_OUTCTL, LSM_OUTCTL_RST);
    @(posedge clk_sys);
    {lock_loss_flag, drive_monitor_flag} <= 2'b00;
    for (int i = 0; i < 4; i++) begin
      wr(LSM_ADDR_RATE, {4'h0, i[1]});
      wr(LSM_ADDR_MONCTL, {4'h0, !i[0]});
      repeat (2) @(posedge clk_sys);
      #1;
      check("decl_thr", declare_thr_mv, thr_d[i]);
      check("clr_thr", clear_thr_mv, thr_c[i]);
    end
    wr(LSM_ADDR_RATE, 5'h02);
    repeat (2) @(posedge clk_sys);
    #1;
    check("decl_thr", declare_thr_mv, 8'h00);
    check("clr_thr", clear_thr_mv, 8'h00);
    bits(200, 1, 0, 1);
    check("loss", {7'h0, signal_loss_flag}, 8'h00);
    wr(LSM_ADDR_RATE, 5'h00);
    wr(LSM_ADDR_MONCTL, 5'h00);
    wr(LSM_ADDR_OUTCTL, 5'h08);
    wr(LSM_ADDR_IRQ_EN, 5'h01);
    bits(150, 1, 0, 1);
    check("loss", {7'h0, signal_loss_flag}, 8'h00);
    bits(15, 1, 0, 1);
    check("loss", {7'h0, signal_loss_flag}, 8'h01);
    check("irq", {7'h0, irq}, 8'h01);
    rd(LSM_ADDR_STATUS, 5'h0a);
    rd(LSM_ADDR_IRQ_ST, 5'h09);
    wr(LSM_ADDR_IRQ_CLR, 5'h0f);
    @(posedge clk_sys);
    #1;
    check("irq", {7'h0, irq}, 8'h00);
    fclr();
    {rail_chk, exp_mute} = 2'b11;
    bits(60, 0, 0, 1);
    rail_chk = 1'b0;
    check("frm_cnt", {7'h0, ones_cnt == 16'h0000}, 8'h01);
    check("loss", {7'h0, signal_loss_flag}, 8'h01);
    bits(40, 0, 0, 1);
    check("loss", {7'h0, signal_loss_flag}, 8'h01);
    bits(40, 0, 0, 1);
    check("loss", {7'h0, signal_loss_flag}, 8'h00);
    rd(LSM_ADDR_STATUS, 5'h00);
    rd(LSM_ADDR_IRQ_ST, 5'h02);
    check("irq", {7'h0, irq}, 8'h00);
    fclr();
    {rail_chk, exp_mute} = 2'b10;
    bits(20, 0, 0, 1);
    rail_chk = 1'b0;
    check("frm_cnt", {7'h0, ones_cnt != 16'h0000}, 8'h01);
    wr(LSM_ADDR_OUTCTL, 5'h00);
    bits(9, 0, 1, 0);
    check("loss", {7'h0, signal_loss_flag}, 8'h00);
    bits(20, 0, 1, 0);
    check("loss", {7'h0, signal_loss_flag}, 8'h01);
    rd(LSM_ADDR_STATUS, 5'h0c);
    rail_chk = 1'b1;
    bits(30, 0, 0, 0);
    rail_chk = 1'b0;
    check("loss", {7'h0, signal_loss_flag}, 8'h01);
    bits(20, 0, 0, 1);
    check("loss", {7'h0, signal_loss_flag}, 8'h00);
    for (int d = 1; d < 4; d++) begin
      wr(LSM_ADDR_MONCTL, {2'h0, d[1:0], 1'b0});
      bits(200, d != 2, d != 1, 0);
      check("loss", {7'h0, signal_loss_flag}, 8'h00);
      rd(LSM_ADDR_STATUS, 5'h00);
    end
    wr(LSM_ADDR_MONCTL, 5'h00);
    @(posedge clk_sys);
    {hw_mode_pin, global_mute_pin} <= 2'b11;
    bits(20, 0, 1, 0);
    check("loss", {7'h0, signal_loss_flag}, 8'h01);
    fclr();
    {rail_chk, exp_mute} = 2'b11;
    bits(20, 0, 1, 0);
    rail_chk = 1'b0;
    check("frm_cnt", {7'h0, ones_cnt == 16'h0000}, 8'h01);
    end_sim();
  end
endmodule
`default_nettype wire
